// File: common/crc_pkg.sv
// package: clock and reset control constants, register map and types
package crc_pkg;
    // bus and register widths
    localparam int DATA_W = 32;
    localparam int ADDR_W = 26;
    localparam int IDX_W = 24;
    localparam int REG_W = 8;
    localparam logic [1:0] WORD_ALIGN = 2'b00;

    // register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL = 24'hfffc40;
    localparam logic [IDX_W-1:0] IDX_FAST_DIV = 24'hfffc42;
    localparam logic [IDX_W-1:0] IDX_SLOW_DIV = 24'hfffc44;
    localparam logic [IDX_W-1:0] IDX_AUX_DIV = 24'hfffc46;
    localparam logic [IDX_W-1:0] IDX_STATUS = 24'hfffc48;
    localparam logic [IDX_W-1:0] IDX_MASK = 24'hfffc4a;

    // divider register reset values and fields
    localparam logic [REG_W-1:0] FAST_DIV_RST = 8'h4f;
    localparam logic [REG_W-1:0] SLOW_DIV_RST = 8'hb6;
    localparam logic [REG_W-1:0] AUX_DIV_RST = 8'hff;
    localparam logic [REG_W-1:0] FAST_DIV_MASK = 8'h7f;
    localparam int FCDIV_MSB = 3;
    localparam int MODE_LSB = 4;
    localparam int MODE_MSB = 6;
    localparam int ACDIV1_MSB = 3;
    localparam int ACDIV2_LSB = 4;
    localparam int ACDIV2_MSB = 7;

    // start-up and reset counters
    localparam int CNT_W = 14;
    localparam logic [CNT_W-1:0] CNT_PRESET = 14'h3fff;
    localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;

    // slow oscillator activity timeout
    localparam int CLK_PERIOD_NS = 100;
    localparam int OSC_TIMEOUT_NS = 100000;
    localparam int SIL_W = 10;
    localparam logic [SIL_W-1:0] OSC_TIMEOUT_CYC = SIL_W'(OSC_TIMEOUT_NS / CLK_PERIOD_NS);

    // tick dividers
    localparam int DIV_W = 9;
    localparam int DIV_N = 4;
    localparam int DIV_SYS = 0;
    localparam int DIV_SLOW = 1;
    localparam int DIV_AUX1 = 2;
    localparam int DIV_AUX2 = 3;

    // asynchronous pin synchroniser lanes
    localparam int SYNC_N = 3;
    localparam int SYNC_EXT = 0;
    localparam int SYNC_PLL = 1;
    localparam int SYNC_OSC = 2;

    // control register layout, bits 5..0; bits 7..6 read zero
    typedef struct packed {
        logic por;
        logic aux_clock2_enable;
        logic aux_clock1_enable;
        logic pll_power_down;
        logic fast_source_select;
        logic slow_source_select;
    } crc_ctrl_t;
    localparam int CTRL_W = 6;
    localparam logic [REG_W-CTRL_W-1:0] RSV_ZERO = 2'b00;
    localparam crc_ctrl_t CTRL_RST = '{por: 1'b1, aux_clock2_enable: 1'b0,
        aux_clock1_enable: 1'b0, pll_power_down: 1'b1, fast_source_select: 1'b1,
        slow_source_select: 1'b0};

    // interrupt status and mask layout
    typedef struct packed {
        logic write_refused;
        logic slow_osc_up;
        logic pll_stable;
        logic reset_released;
        logic main_clock_good;
    } crc_evt_t;
    localparam int EVT_N = 5;

    // reset sequencer states, gray along the power-up path
    typedef enum logic [1:0] {
        ST_OSC_WAIT = 2'b00,
        ST_COUNT = 2'b01,
        ST_RUN = 2'b11
    } crc_seq_t;
endpackage

// File: rtl/crc_clk_div.sv
`timescale 1ns/1ps
// module: programmable tick divider, one tick every terminal plus one cycles
module crc_clk_div
    import crc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic run,
    input wire logic [DIV_W-1:0] terminal,
    output logic tick_q
);
    logic [DIV_W-1:0] cnt_q;

    // count up to terminal, tick and wrap; stopped divider stays clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt_q <= '0;
                tick_q <= 1'b0;
            end else if (cnt_q >= terminal) begin
                cnt_q <= '0;
                tick_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
                tick_q <= 1'b0;
            end
        end
    end
endmodule

// File: rtl/crc_top.sv
`timescale 1ns/1ps
// module: clock and reset control with apb register slave
module crc_top
    import crc_pkg::*;
#(
    parameter logic [CNT_W-1:0] RST_PRESET = CNT_PRESET,
    parameter logic [CNT_W-1:0] OSC_PRESET = CNT_PRESET
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_n,
    input wire logic osc_stop,
    input wire logic pll_locked,
    input wire logic slow_osc_in,
    output logic sys_reset_n,
    output logic main_clock_good,
    output logic main_osc_enable,
    output logic pll_power_down,
    output logic fast_source_select,
    output logic slow_source_select,
    output logic [MODE_MSB-MODE_LSB:0] pll_mode,
    output logic sys_tick,
    output logic slow_tick,
    output logic aux_clock1_tick,
    output logic aux_clock2_tick,
    output logic irq
);
    crc_ctrl_t ctrl_q;
    crc_ctrl_t wdat;
    crc_evt_t status_q;
    crc_evt_t mask_q;
    crc_evt_t evt;
    crc_seq_t state_q;
    logic [REG_W-1:0] fast_div_q;
    logic [REG_W-1:0] slow_div_q;
    logic [REG_W-1:0] aux_div_q;
    logic [REG_W-1:0] rd_byte;
    logic [SYNC_N-1:0] sync1_q;
    logic [SYNC_N-1:0] sync2_q;
    logic [CNT_W-1:0] osc_cnt_q;
    logic [CNT_W-1:0] rst_cnt_q;
    logic [SIL_W-1:0] sil_cnt_q;
    logic [EVT_N-2:0] lvl;
    logic [EVT_N-2:0] lvl_prev_q;
    logic [DIV_W-1:0] div_term [DIV_N];
    logic [DIV_N-1:0] div_run;
    logic [DIV_N-1:0] div_tick;
    logic ext_s;
    logic pll_s;
    logic osc_s;
    logic osc_prev_q;
    logic osc_alive_q;
    logic pll_stable_q;
    logic refused_q;
    logic access;
    logic wr_commit;
    logic rd_commit;
    logic wr_ctrl;
    logic fast_refused;
    logic pwd_refused;
    logic rd_status;

    // byte address match for a register index
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
        hit = (addr == {idx, WORD_ALIGN});
    endfunction

    // true for every implemented register address
    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        mapped = hit(addr, IDX_CTRL) || hit(addr, IDX_FAST_DIV) || hit(addr, IDX_SLOW_DIV)
            || hit(addr, IDX_AUX_DIV) || hit(addr, IDX_STATUS) || hit(addr, IDX_MASK);
    endfunction

    // two-stage synchroniser for the asynchronous pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce) begin
            sync1_q <= {slow_osc_in, pll_locked, ext_reset_n};
            sync2_q <= sync1_q;
        end
    end
    assign ext_s = sync2_q[SYNC_EXT];
    assign pll_s = sync2_q[SYNC_PLL];
    assign osc_s = sync2_q[SYNC_OSC];

    // apb access phase is taken once, answered the next cycle
    assign access = psel && penable && !pready && ce;
    assign wr_commit = access && pwrite;
    assign rd_commit = access && !pwrite;
    assign wr_ctrl = wr_commit && hit(paddr, IDX_CTRL);
    assign rd_status = rd_commit && hit(paddr, IDX_STATUS);
    assign wdat = crc_ctrl_t'(pwdata[CTRL_W-1:0]);

    // refused switch to pll and refused pll power-down
    assign fast_refused = wr_ctrl && !wdat.fast_source_select && ctrl_q.fast_source_select
        && (ctrl_q.pll_power_down || !pll_stable_q);
    assign pwd_refused = wr_ctrl && wdat.pll_power_down && !ctrl_q.pll_power_down
        && !ctrl_q.fast_source_select;

    // apb response registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (ce) begin
            if (access) begin
                pready <= 1'b1;
                pslverr <= !mapped(paddr);
                if (!pwrite) begin
                    prdata <= DATA_W'(rd_byte);
                end
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // read data multiplexer
    always_comb begin
        rd_byte = '0;
        if (hit(paddr, IDX_CTRL)) begin
            rd_byte = {RSV_ZERO, ctrl_q};
        end else if (hit(paddr, IDX_FAST_DIV)) begin
            rd_byte = fast_div_q & FAST_DIV_MASK;
        end else if (hit(paddr, IDX_SLOW_DIV)) begin
            rd_byte = slow_div_q;
        end else if (hit(paddr, IDX_AUX_DIV)) begin
            rd_byte = aux_div_q;
        end else if (hit(paddr, IDX_STATUS)) begin
            rd_byte = REG_W'(status_q);
        end else if (hit(paddr, IDX_MASK)) begin
            rd_byte = REG_W'(mask_q);
        end
    end

    // control register; reserved bits are never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            refused_q <= 1'b0;
        end else if (ce) begin
            refused_q <= fast_refused || pwd_refused;
            if (wr_ctrl) begin
                ctrl_q.slow_source_select <= wdat.slow_source_select;
                ctrl_q.fast_source_select <= wdat.fast_source_select || fast_refused;
                ctrl_q.pll_power_down <= wdat.pll_power_down && !pwd_refused;
                ctrl_q.aux_clock1_enable <= wdat.aux_clock1_enable;
                ctrl_q.aux_clock2_enable <= wdat.aux_clock2_enable;
                ctrl_q.por <= ctrl_q.por && wdat.por;
            end
        end
    end

    // divider registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_div_q <= FAST_DIV_RST;
            slow_div_q <= SLOW_DIV_RST;
            aux_div_q <= AUX_DIV_RST;
        end else if (ce && wr_commit) begin
            if (hit(paddr, IDX_FAST_DIV)) begin
                fast_div_q <= pwdata[REG_W-1:0] & FAST_DIV_MASK;
            end
            if (hit(paddr, IDX_SLOW_DIV)) begin
                slow_div_q <= pwdata[REG_W-1:0];
            end
            if (hit(paddr, IDX_AUX_DIV)) begin
                aux_div_q <= pwdata[REG_W-1:0];
            end
        end
    end

    // main oscillator start-up counter and good flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_q <= OSC_PRESET;
            main_clock_good <= 1'b0;
            main_osc_enable <= 1'b1;
        end else if (ce) begin
            main_osc_enable <= !osc_stop;
            if (osc_stop) begin
                osc_cnt_q <= OSC_PRESET;
                main_clock_good <= 1'b0;
            end else if (osc_cnt_q != CNT_ZERO) begin
                osc_cnt_q <= osc_cnt_q - CNT_ONE;
                main_clock_good <= (osc_cnt_q == CNT_ONE);
            end else begin
                main_clock_good <= 1'b1;
            end
        end
    end

    // internal reset sequencer and 14-bit reset counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_OSC_WAIT;
            rst_cnt_q <= RST_PRESET;
            sys_reset_n <= 1'b0;
        end else if (ce) begin
            if (!ext_s) begin
                rst_cnt_q <= RST_PRESET;
                sys_reset_n <= 1'b0;
                state_q <= main_clock_good ? ST_COUNT : ST_OSC_WAIT;
            end else begin
                case (state_q)
                    ST_OSC_WAIT: begin
                        if (main_clock_good) begin
                            state_q <= ST_COUNT;
                        end
                    end
                    ST_COUNT: begin
                        if (main_clock_good) begin
                            if (rst_cnt_q == CNT_ZERO) begin
                                state_q <= ST_RUN;
                                sys_reset_n <= 1'b1;
                            end else begin
                                rst_cnt_q <= rst_cnt_q - CNT_ONE;
                            end
                        end
                    end
                    ST_RUN: begin
                        sys_reset_n <= 1'b1;
                    end
                    default: begin
                        state_q <= ST_OSC_WAIT;
                        sys_reset_n <= 1'b0;
                    end
                endcase
            end
        end
    end

    // pll stable only while powered up and locked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_stable_q <= 1'b0;
        end else if (ce) begin
            pll_stable_q <= pll_s && !ctrl_q.pll_power_down;
        end
    end

    // slow oscillator activity detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_prev_q <= 1'b0;
            sil_cnt_q <= '0;
            osc_alive_q <= 1'b0;
        end else if (ce) begin
            osc_prev_q <= osc_s;
            if (osc_s != osc_prev_q) begin
                sil_cnt_q <= '0;
                osc_alive_q <= 1'b1;
            end else if (sil_cnt_q == OSC_TIMEOUT_CYC) begin
                osc_alive_q <= 1'b0;
            end else begin
                sil_cnt_q <= sil_cnt_q + 1'b1;
            end
        end
    end

    // effective slow source and slow tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_source_select <= 1'b0;
            slow_tick <= 1'b0;
        end else if (ce) begin
            slow_source_select <= ctrl_q.slow_source_select && osc_alive_q;
            slow_tick <= slow_source_select ? (osc_s && !osc_prev_q) : div_tick[DIV_SLOW];
        end
    end

    // divider terminals and run conditions
    assign div_term[DIV_SYS] = DIV_W'(fast_div_q[FCDIV_MSB:0]);
    assign div_term[DIV_SLOW] = {slow_div_q, 1'b1};
    assign div_term[DIV_AUX1] = DIV_W'(aux_div_q[ACDIV1_MSB:0]);
    assign div_term[DIV_AUX2] = DIV_W'(aux_div_q[ACDIV2_MSB:ACDIV2_LSB]);
    assign div_run[DIV_SYS] = 1'b1;
    assign div_run[DIV_SLOW] = !slow_source_select;
    assign div_run[DIV_AUX1] = ctrl_q.aux_clock1_enable && main_clock_good;
    assign div_run[DIV_AUX2] = ctrl_q.aux_clock2_enable && main_clock_good;

    // tick dividers
    for (genvar i = 0; i < DIV_N; i++) begin : g_div
        crc_clk_div u_div (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .run(div_run[i]),
            .terminal(div_term[i]),
            .tick_q(div_tick[i])
        );
    end

    // outputs taken straight from register or divider flops
    assign sys_tick = div_tick[DIV_SYS];
    assign aux_clock1_tick = div_tick[DIV_AUX1];
    assign aux_clock2_tick = div_tick[DIV_AUX2];
    assign pll_power_down = ctrl_q.pll_power_down;
    assign fast_source_select = ctrl_q.fast_source_select;
    assign pll_mode = fast_div_q[MODE_MSB:MODE_LSB];

    // rising-edge events and the registered write-refused pulse for the interrupt status
    assign lvl = {osc_alive_q, pll_stable_q, sys_reset_n, main_clock_good};
    assign evt = crc_evt_t'({refused_q, lvl & ~lvl_prev_q});

    // sticky status cleared by read, set wins; mask and level interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_prev_q <= '0;
            status_q <= '0;
            mask_q <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            lvl_prev_q <= lvl;
            status_q <= (rd_status ? crc_evt_t'('0) : status_q) | evt;
            if (wr_commit && hit(paddr, IDX_MASK)) begin
                mask_q <= crc_evt_t'(pwdata[EVT_N-1:0]);
            end
            irq <= |(status_q & mask_q);
        end
    end

    // checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cnt_wait: assert property (
        ce && ext_s && !main_clock_good |=> rst_cnt_q == $past(rst_cnt_q))
        else $error("reset counter moved before main clock good");
    a_rst_hold: assert property (
        ce && !ext_s |=> !sys_reset_n)
        else $error("internal reset released while pin low");
    a_rst_release: assert property (
        ce && ext_s && main_clock_good && state_q == ST_COUNT && rst_cnt_q == CNT_ZERO
        |=> sys_reset_n && state_q == ST_RUN)
        else $error("internal reset not released at count zero");
    a_cnt_reload: assert property (
        ce && !ext_s |=> rst_cnt_q == RST_PRESET)
        else $error("reset counter not restarted by pin");
    a_fast_refuse: assert property (
        ce && wr_ctrl && !wdat.fast_source_select && (ctrl_q.pll_power_down || !pll_stable_q)
        && ctrl_q.fast_source_select |=> ctrl_q.fast_source_select && evt.write_refused)
        else $error("switch to pll taken while pll unusable");
    a_pwd_refuse: assert property (
        ce && wr_ctrl && !ctrl_q.fast_source_select && !ctrl_q.pll_power_down
        |=> !pll_power_down)
        else $error("pll powered down while selected");
    a_aux1_gate: assert property (
        aux_clock1_tick |-> $past(ctrl_q.aux_clock1_enable && main_clock_good))
        else $error("aux clock 1 ran while gated");
    a_aux2_gate: assert property (
        aux_clock2_tick |-> $past(ctrl_q.aux_clock2_enable && main_clock_good))
        else $error("aux clock 2 ran while gated");
    a_por_keep: assert property (
        ce && wr_ctrl && pwdata[CTRL_W-1] |=> ctrl_q.por == $past(ctrl_q.por))
        else $error("power-on flag changed by a written one");
    a_good_zero: assert property (
        ce && !osc_stop && osc_cnt_q == CNT_ONE ##1 !(ce && osc_stop) |-> main_clock_good)
        else $error("main clock good missing at count zero");
    a_slow_gate: assert property (
        slow_source_select |-> $past(osc_alive_q && ctrl_q.slow_source_select))
        else $error("slow oscillator used while not toggling");
    a_rsv_zero: assert property (
        pready && !pslverr && $past(rd_commit && hit(paddr, IDX_CTRL))
        |-> prdata[REG_W-1:CTRL_W] == RSV_ZERO)
        else $error("reserved control bits read nonzero");
    a_irq_level: assert property (
        ce |=> irq == |($past(status_q) & $past(mask_q)))
        else $error("interrupt output does not follow status and mask");
endmodule

// File: tb/crc_top_bench.sv
`timescale 1ns/1ps
// testbench: control register, start-up counters, clock gating and interrupt checks
module crc_top_bench;
    import crc_pkg::*;
    localparam logic [CNT_W-1:0] RP = 14'h0010;
    localparam logic [CNT_W-1:0] OP = 14'h0010;
    localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, WORD_ALIGN};
    localparam logic [ADDR_W-1:0] A_FDIV = {IDX_FAST_DIV, WORD_ALIGN};
    localparam logic [ADDR_W-1:0] A_SDIV = {IDX_SLOW_DIV, WORD_ALIGN};
    localparam logic [ADDR_W-1:0] A_ADIV = {IDX_AUX_DIV, WORD_ALIGN};
    localparam logic [ADDR_W-1:0] A_STAT = {IDX_STATUS, WORD_ALIGN};
    localparam logic [ADDR_W-1:0] A_MASK = {IDX_MASK, WORD_ALIGN};
    localparam logic [ADDR_W-1:0] A_BAD = {IDX_CTRL + 24'h000001, WORD_ALIGN};
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, r;
    logic ext_reset_n, osc_stop, pll_locked, slow_osc_in, osc_run, sys_reset_n;
    logic main_clock_good, main_osc_enable, pll_power_down, fast_source_select;
    logic slow_source_select, sys_tick, slow_tick, aux_clock1_tick, aux_clock2_tick;
    logic [MODE_MSB-MODE_LSB:0] pll_mode;
    logic [2:0] tg;
    logic [64:0] note_q[$];
    logic [64:0] nt;
    int error_cnt, check_count, n;
    logic [31:0] c1, c2, c3, c4;

    crc_top #(.RST_PRESET(RP), .OSC_PRESET(OP)) u_dut (.pclk, .presetn, .ce, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .ext_reset_n, .osc_stop,
        .pll_locked, .slow_osc_in, .sys_reset_n, .main_clock_good, .main_osc_enable,
        .pll_power_down, .fast_source_select, .slow_source_select, .pll_mode, .sys_tick,
        .slow_tick, .aux_clock1_tick, .aux_clock2_tick, .irq);

    // clock, 100 ns period
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task end_sim();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // one apb transfer; reads note {err, mask, expected} for the monitor
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
        input logic [31:0] m, input logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) note_q.push_back({err, m, d});
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            chk("pready", 1, 0);
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 0, 1'b0);
    endtask

    task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, e, m, 1'b0);
    endtask

    // count aux, system and slow ticks over a window of len cycles
    task ticks(input int len);
        c1 = 0;
        c2 = 0;
        c3 = 0;
        c4 = 0;
        repeat (len) begin
            @(posedge pclk);
            c1 += aux_clock1_tick;
            c2 += aux_clock2_tick;
            c3 += sys_tick;
            c4 += slow_tick;
        end
    endtask

    // read monitor: oldest note against the answer
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (note_q.size() == 0) chk("note", 0, 1);
            else begin
                nt = note_q.pop_front();
                chk("prdata", nt[31:0], prdata & nt[63:32]);
                chk("pslverr", {31'h0, nt[64]}, {31'h0, pslverr});
            end
        end
    end

    // slow oscillator stand-in, toggles only while osc_run
    always @(posedge pclk) begin
        tg <= tg + 3'h1;
        if (osc_run && tg == 3'h0) slow_osc_in <= ~slow_osc_in;
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge pclk);
        chk("timeout", 0, 1);
        end_sim();
    end

    initial begin
        {presetn, psel, penable, pwrite, osc_stop, pll_locked, slow_osc_in, osc_run} = 8'h00;
        {ce, ext_reset_n} = 2'b11;
        paddr = '0;
        pwdata = '0;
        tg = 3'h0;
        r = $urandom(4);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (n = 0; n < 200 && main_clock_good !== 1'b1; n++) begin
            chk("sys_reset_n", 0, sys_reset_n);
            @(posedge pclk);
        end
        chk("osc count", 1, n >= OP && n < 200);
        for (n = 0; n < 200 && sys_reset_n !== 1'b1; n++) @(posedge pclk);
        chk("reset count", 1, n >= RP && n < 200);
        $display("test startup done");
        wr(A_BAD, 32'h000000ff);
        apb(1'b0, A_BAD, 0, 32'hffffffff, 1'b1);
        rd(A_CTRL, 32'h26, 32'hffffffff);
        wr(A_CTRL, 32'h26);
        rd(A_CTRL, 32'h26, 32'hffffffff);
        rd(A_SDIV, {24'h0, SLOW_DIV_RST}, 32'hffffffff);
        rd(A_MASK, 0, 32'hffffffff);
        rd(A_STAT, 32'h03, 32'hffffffff);
        r = $urandom;
        wr(A_FDIV, r);
        rd(A_FDIV, r & 32'h7f, 32'hffffffff);
        chk("pll_mode", {29'h0, r[6:4]}, {29'h0, pll_mode});
        ticks(4 * (SLOW_DIV_RST + 1) * (r[3:0] + 1));
        chk("sys ticks", 4 * (SLOW_DIV_RST + 1), c3);
        chk("slow ticks", 2 * (r[3:0] + 1), c4);
        wr(A_CTRL, 32'hd8);
        rd(A_CTRL, 32'h1a, 32'hffffffff);
        chk("fast", 1, fast_source_select);
        chk("pwd", 0, pll_power_down);
        $display("test register done");
        r = $urandom;
        wr(A_ADIV, r);
        repeat (20) @(posedge pclk);
        ticks(4 * (r[3:0] + 1) * (r[7:4] + 1));
        chk("aux1 count", 4 * (r[7:4] + 1), c1);
        chk("aux2 count", 4 * (r[3:0] + 1), c2);
        osc_stop <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("osc enable", 0, main_osc_enable);
        ticks(64);
        chk("aux stopped", 0, c1 + c2);
        osc_stop <= 1'b0;
        for (n = 0; n < 200 && main_clock_good !== 1'b1; n++) @(posedge pclk);
        chk("osc restart", 1, n >= OP && n < 200);
        wr(A_CTRL, 32'h02);
        ticks(64);
        chk("aux disabled", 0, c1 + c2);
        $display("test aux done");
        wr(A_CTRL, 32'h00);
        rd(A_CTRL, 32'h02, 32'hffffffff);
        pll_locked <= 1'b1;
        repeat (10) @(posedge pclk);
        rd(A_STAT, 32'h04, 32'h04);
        wr(A_CTRL, 32'h20);
        rd(A_CTRL, 32'h00, 32'hffffffff);
        chk("fast", 0, fast_source_select);
        wr(A_CTRL, 32'h04);
        rd(A_CTRL, 32'h00, 32'hffffffff);
        wr(A_CTRL, 32'h06);
        rd(A_CTRL, 32'h02, 32'hffffffff);
        wr(A_CTRL, 32'h06);
        rd(A_CTRL, 32'h06, 32'hffffffff);
        chk("pwd", 1, pll_power_down);
        $display("test pll done");
        wr(A_MASK, 32'h10);
        rd(A_STAT, 0, 0);
        repeat (4) @(posedge pclk);
        chk("irq idle", 0, irq);
        wr(A_CTRL, 32'h04);
        for (n = 0; n < 6 && irq !== 1'b1; n++) @(posedge pclk);
        chk("irq raised", 1, irq);
        rd(A_STAT, 32'h10, 32'h10);
        repeat (4) @(posedge pclk);
        chk("irq cleared", 0, irq);
        wr(A_MASK, 32'h00);
        wr(A_CTRL, 32'h04);
        repeat (6) @(posedge pclk);
        chk("irq masked", 0, irq);
        rd(A_STAT, 32'h10, 32'h10);
        $display("test interrupt done");
        wr(A_CTRL, 32'h07);
        repeat (10) @(posedge pclk);
        chk("slow quiet", 0, slow_source_select);
        osc_run <= 1'b1;
        for (n = 0; n < 100 && slow_source_select !== 1'b1; n++) @(posedge pclk);
        chk("slow osc", 1, slow_source_select);
        osc_run <= 1'b0;
        for (n = 0; n < 1200 && slow_source_select !== 1'b0; n++) @(posedge pclk);
        chk("slow fallback", 1, n > 900 && n < 1200);
        rd(A_CTRL, 32'h07, 32'hffffffff);
        $display("test slow done");
        ext_reset_n <= 1'b0;
        repeat (50) @(posedge pclk);
        chk("held", 0, sys_reset_n);
        ext_reset_n <= 1'b1;
        for (n = 0; n < 200 && sys_reset_n !== 1'b1; n++) @(posedge pclk);
        chk("ext count", 1, n >= RP && n < 200);
        rd(A_CTRL, 32'h07, 32'hffffffff);
        $display("test external reset done");
        repeat (5) @(posedge pclk);
        chk("notes left", 0, note_q.size());
        end_sim();
    end
endmodule
